// ---- include/dpsc_pkg.sv ----
/*
  Package of constants for the debug port system control block: register
  offsets, field positions, reset values, codes and clock divider figures.
  Assumes one 125 MHz clock feeding every user of these constants.
*/
package dpsc_pkg;

  // ----------------------------------------------------------------------
  // register offsets on the debug register port
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_RESET_REQUEST = 8'h08;
  localparam logic [7:0] OFS_CLOCK_DIVIDER = 8'h09;
  localparam logic [7:0] OFS_SYS_CONTROL   = 8'h0a;
  localparam logic [7:0] OFS_SYS_STATUS    = 8'h0b;
  localparam logic [7:0] OFS_CRC_STATUS    = 8'h0c;

  // ----------------------------------------------------------------------
  // codes and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RESET_CODE_RUN    = 8'h00;
  localparam logic [7:0] RESET_CODE_NORMAL = 8'h59;
  localparam logic [1:0] CLKSEL_16MHZ      = 2'h1;
  localparam logic [1:0] CLKSEL_8MHZ       = 2'h2;
  localparam logic [1:0] CLKSEL_4MHZ       = 2'h3;
  localparam logic [1:0] CLKSEL_RESET      = CLKSEL_4MHZ;
  localparam logic [7:0] STATUS_RESET      = 8'h01;
  localparam logic [2:0] CRC_RESET         = 3'h0;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_CLOCK_REQUEST = 0;
  localparam int CTRL_USER_ROW_DONE = 1;
  localparam int ST_LOCKED          = 0;
  localparam int ST_BOOT_COMPLETE   = 1;
  localparam int ST_UROW_READY      = 2;
  localparam int ST_NVM_READY       = 3;
  localparam int ST_ASLEEP          = 4;
  localparam int ST_RESET_ACTIVE    = 5;
  localparam int ST_ERASE_FAILED    = 6;
  localparam int ST_BOOT_OR_FAIL    = 7;

  // ----------------------------------------------------------------------
  // debug clock divider, rates in kHz
  // ----------------------------------------------------------------------
  localparam int CLK_KHZ      = 125000;
  localparam int DBG_16M_KHZ  = 16000;
  localparam int DBG_8M_KHZ   = 8000;
  localparam int DBG_4M_KHZ   = 4000;
  localparam int DIV_W        = 6;
  // period as whole clock cycles, rounded down so the tick is never slower
  localparam logic [DIV_W-1:0] DIV_16M = DIV_W'(CLK_KHZ / DBG_16M_KHZ - 1);
  localparam logic [DIV_W-1:0] DIV_8M  = DIV_W'(CLK_KHZ / DBG_8M_KHZ - 1);
  localparam logic [DIV_W-1:0] DIV_4M  = DIV_W'(CLK_KHZ / DBG_4M_KHZ - 1);

endpackage

// ---- rtl/dpsc_sync.sv ----
/*
  Three-stage synchroniser for a bundle of independent level bits.
  Assumes each bit is a slow level from another domain; bits are not
  coherent with each other as a word.
*/
`timescale 1ns/1ps
module dpsc_sync
#(
  parameter int         WIDTH   = 1,
  parameter logic [7:0] RST_VAL = 8'h00
)
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  if (WIDTH < 1 || WIDTH > 8)
  begin : g_chk
    $error("dpsc_sync width must be 1 to 8");
  end

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } dpsc_sync_t;

  dpsc_sync_t st;
  dpsc_sync_t next_st;

  // ----------------------------------------------------------------------
  // per-bit stages; the first stage feeds only the second
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_st    = st;
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < WIDTH; i++)
    begin
      // a change counts only once stages two and three agree
      if (st.s2[i] == st.s3[i])
      begin
        next_st.q[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st.s1 <= RST_VAL[WIDTH-1:0];
      st.s2 <= RST_VAL[WIDTH-1:0];
      st.s3 <= RST_VAL[WIDTH-1:0];
      st.q  <= RST_VAL[WIDTH-1:0];
    end
    else
    begin
      st <= next_st;
    end
  end

  assign sync_out = st.q;

endmodule

// ---- rtl/dpsc_ctrl.sv ----
/*
  System-side control and status registers of the single-wire debug
  interface: reset request, debug clock select, system clock request,
  user row hand-off, system status and CRC status.
  Assumes the debug interface decodes its own link and presents byte
  accesses on a simple register port in the clk domain; system-side
  status levels arrive from another domain and are synchronised here.
*/
// What this block does
// R1 - code 0x59 asserts system reset, 0x00 clears it, other codes ignored
// R2 - clock select 1, 2, 3 give 16, 8, 4 MHz debug clock
// R3 - clock select resets to 4 MHz setting, also on interface enable
// R4 - writing one to user row done starts user row programming
// R5 - programmer writes user row done only after data is in RAM
// R6 - user row done write ignored unless user row key decoded
// R7 - clock request bit one keeps system clock running through sleep
// R8 - writing zero to clock request withdraws the system clock request
// R9 - clock request set automatically whenever debug interface becomes enabled
// R10 - status bit 7 is erase failed OR boot complete
// R11 - erase failed set on failed erase, cleared by any system reset
// R12 - reset active flag set during system reset, cleared on read
// R13 - asleep flag follows system idle or deeper sleep
// R14 - nvm program ready flag shows programming through debug allowed
// R15 - programmer resets system through reset request after nvm programming
// R16 - device flags user row ready; programmer then writes user row done
// R17 - boot complete flag set after boot; access layer refused until then
// R18 - programmer checks reset active is zero before access layer work
// R19 - locked flag resets to one, reads zero after unlocking erase
// R20 - CRC status field one-hot: idle, busy, pass, fail
// R21 - requested system reset held until clear code written
`timescale 1ns/1ps
module dpsc_ctrl
#(
  parameter int SYS_IN_W = 8
)
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // register port from the debug link
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_we,
  input  wire logic       reg_re,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  // debug interface state, same clock
  input  wire logic       debug_enable,
  input  wire logic       user_row_key_ok,
  // system domain levels, asynchronous
  input  wire logic       sys_in_reset,
  input  wire logic       sys_asleep,
  input  wire logic       sys_boot_done,
  input  wire logic       sys_erase_fail,
  input  wire logic       sys_nvm_ready,
  input  wire logic       sys_urow_ready,
  input  wire logic       sys_locked,
  input  wire logic [2:0] sys_crc_status,
  // controls toward the system
  output logic            sys_reset_request,
  output logic            system_clock_request,
  output logic            user_row_program,
  output logic            access_layer_enable,
  output logic            debug_clock_tick
);

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  if (SYS_IN_W != 8)
  begin : g_chk
    $error("dpsc_ctrl expects eight system status levels");
  end

  // ----------------------------------------------------------------------
  // synchronised system levels
  // ----------------------------------------------------------------------
  logic [SYS_IN_W-1:0] sys_raw;
  logic [SYS_IN_W-1:0] sys_sync;
  logic [2:0]          crc_sync;

  assign sys_raw = {sys_in_reset, sys_asleep, sys_boot_done, sys_erase_fail,
                    sys_nvm_ready, sys_urow_ready, sys_locked, 1'b0};

  // locked level starts at one so status reads its reset value
  dpsc_sync
  #(
    .WIDTH   (SYS_IN_W),
    .RST_VAL (8'h02)
  )
  u_sys_sync
  (
    .clk      (clk),
    .srst     (srst),
    .async_in (sys_raw),
    .sync_out (sys_sync)
  );

  dpsc_sync
  #(
    .WIDTH   (3),
    .RST_VAL ({5'h00, dpsc_pkg::CRC_RESET})
  )
  u_crc_sync
  (
    .clk      (clk),
    .srst     (srst),
    .async_in (sys_crc_status),
    .sync_out (crc_sync)
  );

  logic s_in_reset;
  logic s_asleep;
  logic s_boot;
  logic s_erase_fail;
  logic s_nvm_ready;
  logic s_urow_ready;
  logic s_locked;

  assign s_in_reset   = sys_sync[7];
  assign s_asleep     = sys_sync[6];
  assign s_boot       = sys_sync[5];
  assign s_erase_fail = sys_sync[4];
  assign s_nvm_ready  = sys_sync[3];
  assign s_urow_ready = sys_sync[2];
  assign s_locked     = sys_sync[1];

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic                        rst_req;
    logic [1:0]                  clk_sel;
    logic                        clk_req;
    logic                        urow_go;
    logic                        erase_failed;
    logic                        reset_seen;
    logic                        enable_d;
    logic [7:0]                  rdata;
    logic                        rvalid;
    logic                        acc_en;
    logic [dpsc_pkg::DIV_W-1:0] div_cnt;
    logic                        tick;
  } dpsc_state_t;

  dpsc_state_t st;
  dpsc_state_t next_st;

  logic [7:0]                  status_word;
  logic [dpsc_pkg::DIV_W-1:0] div_limit;
  logic                        any_reset;
  logic                        enable_rise;

  // ----------------------------------------------------------------------
  // status word assembly
  // ----------------------------------------------------------------------
  always_comb
  begin
    status_word                              = 8'h00;
    status_word[dpsc_pkg::ST_LOCKED]         = s_locked;                       // R19
    status_word[dpsc_pkg::ST_BOOT_COMPLETE]  = s_boot;                         // R17
    status_word[dpsc_pkg::ST_UROW_READY]     = s_urow_ready;                   // R16
    status_word[dpsc_pkg::ST_NVM_READY]      = s_nvm_ready;                    // R14
    status_word[dpsc_pkg::ST_ASLEEP]         = s_asleep;                       // R13
    status_word[dpsc_pkg::ST_RESET_ACTIVE]   = st.reset_seen;                  // R12
    status_word[dpsc_pkg::ST_ERASE_FAILED]   = st.erase_failed;                // R11
    status_word[dpsc_pkg::ST_BOOT_OR_FAIL]   = st.erase_failed | s_boot;       // R10
  end

  // ----------------------------------------------------------------------
  // debug clock period select; reserved code stops the tick
  // ----------------------------------------------------------------------
  always_comb
  begin
    unique case (st.clk_sel)                                                   // R2
      dpsc_pkg::CLKSEL_16MHZ:
      begin
        div_limit = dpsc_pkg::DIV_16M;
      end
      dpsc_pkg::CLKSEL_8MHZ:
      begin
        div_limit = dpsc_pkg::DIV_8M;
      end
      dpsc_pkg::CLKSEL_4MHZ:
      begin
        div_limit = dpsc_pkg::DIV_4M;
      end
      default:
      begin
        div_limit = '0;
      end
    endcase
  end

  // own reset request counts too, since the system sees it before it echoes
  assign any_reset   = s_in_reset | st.rst_req;
  assign enable_rise = debug_enable & ~st.enable_d;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_st          = st;
    next_st.enable_d = debug_enable;
    next_st.rvalid   = reg_re;
    next_st.urow_go  = 1'b0;

    // register writes
    if (reg_we)
    begin
      unique case (reg_addr)
        dpsc_pkg::OFS_RESET_REQUEST:
        begin
          if (reg_wdata == dpsc_pkg::RESET_CODE_NORMAL)
          begin
            next_st.rst_req = 1'b1;                                            // R1
          end
          else if (reg_wdata == dpsc_pkg::RESET_CODE_RUN)
          begin
            next_st.rst_req = 1'b0;                                            // R21
          end
        end
        dpsc_pkg::OFS_CLOCK_DIVIDER:
        begin
          next_st.clk_sel = reg_wdata[1:0];                                    // R2
        end
        dpsc_pkg::OFS_SYS_CONTROL:
        begin
          next_st.clk_req = reg_wdata[dpsc_pkg::CTRL_CLOCK_REQUEST];           // R8
          if (user_row_key_ok && reg_wdata[dpsc_pkg::CTRL_USER_ROW_DONE])      // R6
          begin
            next_st.urow_go = 1'b1;                                            // R4
          end
        end
        default:
        begin
          next_st.clk_req = st.clk_req;
        end
      endcase
    end

    // enabling the interface restores the reset clock select and asks for the clock
    if (enable_rise)
    begin
      next_st.clk_sel = dpsc_pkg::CLKSEL_RESET;                                // R3
      next_st.clk_req = 1'b1;                                                  // R9
    end

    // read data; status read clears reset flag, but a live reset re-sets it
    if (reg_re)
    begin
      unique case (reg_addr)
        dpsc_pkg::OFS_RESET_REQUEST:
        begin
          next_st.rdata = st.rst_req ? dpsc_pkg::RESET_CODE_NORMAL : dpsc_pkg::RESET_CODE_RUN;
        end
        dpsc_pkg::OFS_CLOCK_DIVIDER:
        begin
          next_st.rdata = {6'h00, st.clk_sel};
        end
        dpsc_pkg::OFS_SYS_CONTROL:
        begin
          next_st.rdata = {7'h00, st.clk_req};
        end
        dpsc_pkg::OFS_SYS_STATUS:
        begin
          next_st.rdata = status_word;
        end
        dpsc_pkg::OFS_CRC_STATUS:
        begin
          next_st.rdata = {5'h00, crc_sync};                                   // R20
        end
        default:
        begin
          next_st.rdata = 8'h00;
        end
      endcase
    end

    if (reg_re && reg_addr == dpsc_pkg::OFS_SYS_STATUS)
    begin
      next_st.reset_seen = 1'b0;                                               // R12
    end
    if (any_reset)
    begin
      next_st.reset_seen = 1'b1;                                               // R12
    end

    // a reset wipes a failure; a failure during reset is lost with it
    if (any_reset)
    begin
      next_st.erase_failed = 1'b0;                                             // R11
    end
    else if (s_erase_fail)
    begin
      next_st.erase_failed = 1'b1;                                             // R11
    end

    // no access layer while booting or while the system sits in reset
    next_st.acc_en = s_boot & ~any_reset;                                      // R17

    // debug clock enable divider
    if (div_limit == '0)
    begin
      next_st.div_cnt = '0;
      next_st.tick    = 1'b0;
    end
    else if (st.div_cnt >= div_limit)
    begin
      next_st.div_cnt = '0;
      next_st.tick    = 1'b1;
    end
    else
    begin
      next_st.div_cnt = st.div_cnt + 1'b1;
      next_st.tick    = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st              <= '0;
      st.clk_sel      <= dpsc_pkg::CLKSEL_RESET;                               // R3
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, each straight from a flop
  // ----------------------------------------------------------------------
  // reset request lives here, so the srst of this block is never driven by it
  assign sys_reset_request    = st.rst_req;                                    // R1
  assign system_clock_request = st.clk_req;                                    // R7
  assign user_row_program     = st.urow_go;                                    // R4
  assign access_layer_enable  = st.acc_en;                                     // R17
  assign debug_clock_tick     = st.tick;                                       // R2
  assign reg_rdata            = st.rdata;
  assign reg_rvalid           = st.rvalid;

endmodule

// ---- testbench/dpsc_sys_model.sv ----
/*
  System domain model: follows the requested reset, runs a short boot
  after it, and keeps a failed chip erase until the next reset.
  Assumes clk is the block clock; levels reach the block unsynchronised.
*/
`timescale 1ns/1ps
module dpsc_sys_model
#(
  parameter int BOOT_CYC = 12
)
(
  // clock
  input wire logic clk,
  // from the block and the bench
  input wire logic reset_req,
  input wire logic erase_bad,
  // system levels
  output logic     in_reset,
  output logic     boot_done,
  output logic     erase_fail
);
  int cnt = 0;

  always @(posedge clk)
  begin
    in_reset <= reset_req === 1'b1;
    cnt <= in_reset ? 0 : (cnt < BOOT_CYC ? cnt + 1 : cnt);
    boot_done <= !in_reset && cnt == BOOT_CYC;
    erase_fail <= !in_reset && (erase_fail === 1'b1 || erase_bad);
  end
endmodule

// ---- testbench/dpsc_ctrl_sva.sv ----
/*
  Checker for the dpsc_ctrl register port and control outputs.
  Assumes one clock and srst synchronous, active high.
*/
`timescale 1ns/1ps
module dpsc_ctrl_sva
(
  // clock and reset
  input wire logic       clk,
  input wire logic       srst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_we,
  input wire logic       reg_re,
  input wire logic [7:0] reg_rdata,
  // levels and controls
  input wire logic       debug_enable,
  input wire logic       user_row_key_ok,
  input wire logic       sys_boot_done,
  input wire logic       sys_reset_request,
  input wire logic       system_clock_request,
  input wire logic       user_row_program,
  input wire logic       access_layer_enable,
  input wire logic       debug_clock_tick
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  sequence rst_set_s;
    reg_we && reg_addr == 8'h08 && reg_wdata == dpsc_pkg::RESET_CODE_NORMAL;
  endsequence
  sequence urow_wr_s;
    reg_we && reg_addr == 8'h0a && reg_wdata[1] && user_row_key_ok;
  endsequence
  // a rise of debug_enable would win over the write, so keep it steady
  sequence clk_off_s;
    reg_we && reg_addr == 8'h0a && !reg_wdata[0] && debug_enable == $past(debug_enable)
      && debug_enable == $past(debug_enable, 2);
  endsequence

  rst_set_a: assert property (rst_set_s |=> sys_reset_request)
    else $error("reset request not raised");
  rst_clr_a: assert property (reg_we && reg_addr == 8'h08 && reg_wdata == 8'h00 |=> !sys_reset_request)
    else $error("reset request not cleared");
  rst_held_a: assert property ($changed(sys_reset_request) |-> $past(reg_we) && $past(reg_addr) == 8'h08)
    else $error("reset request moved without a write");
  rd_req_a: assert property (reg_re && reg_addr == 8'h08 |=> reg_rdata == ($past(sys_reset_request) ? 8'h59 : 8'h00))
    else $error("reset request readback wrong");
  urow_go_a: assert property (urow_wr_s |=> user_row_program)
    else $error("user row start missing");
  urow_key_a: assert property (user_row_program |-> $past(user_row_key_ok) && $past(reg_we))
    else $error("user row start without key");
  clk_on_a: assert property ($rose(debug_enable) |-> ##[1:2] system_clock_request)
    else $error("clock request not set on enable");
  clk_off_a: assert property (clk_off_s |=> !system_clock_request)
    else $error("clock request not withdrawn");
  tick_gap_a: assert property (debug_clock_tick |=> !debug_clock_tick [*6])
    else $error("debug tick too fast");
  acc_boot_a: assert property (!sys_boot_done [*8] |-> !access_layer_enable)
    else $error("access layer open before boot");
endmodule

bind dpsc_ctrl dpsc_ctrl_sva dpsc_ctrl_sva_i
(
  .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
  .reg_rdata(reg_rdata), .debug_enable(debug_enable), .user_row_key_ok(user_row_key_ok),
  .sys_boot_done(sys_boot_done), .sys_reset_request(sys_reset_request),
  .system_clock_request(system_clock_request), .user_row_program(user_row_program),
  .access_layer_enable(access_layer_enable), .debug_clock_tick(debug_clock_tick)
);

// ---- testbench/testbench.sv ----
/*
  Self-checking bench for dpsc_ctrl: byte reads and writes on the register
  port, system levels from dpsc_sys_model and from the bench.
  Assumes the checker binds itself to dpsc_ctrl.
*/
`timescale 1ns/1ps
module testbench;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_we = 1'b0;
  logic       reg_re = 1'b0;
  logic       debug_enable = 1'b0;
  logic       user_row_key_ok = 1'b0;
  logic       sys_asleep = 1'b0;
  logic       sys_nvm_ready = 1'b0;
  logic       sys_urow_ready = 1'b0;
  logic       sys_locked = 1'b1;
  logic       erase_bad = 1'b0;
  logic [2:0] sys_crc_status = 3'h0;
  logic [7:0] reg_rdata;
  logic       reg_rvalid, sys_in_reset, sys_boot_done, sys_erase_fail, sys_reset_request;
  logic       system_clock_request, user_row_program, access_layer_enable, debug_clock_tick;
  logic [5:0] div_v [1:3] = '{dpsc_pkg::DIV_16M, dpsc_pkg::DIV_8M, dpsc_pkg::DIV_4M};
  int         err_total = 0;
  int         n_checks = 0;
  int         gap;

  always #4 clk = ~clk;

  dpsc_ctrl dpsc_ctrl_i
  (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .debug_enable(debug_enable), .user_row_key_ok(user_row_key_ok),
    .sys_in_reset(sys_in_reset), .sys_asleep(sys_asleep), .sys_boot_done(sys_boot_done),
    .sys_erase_fail(sys_erase_fail), .sys_nvm_ready(sys_nvm_ready), .sys_urow_ready(sys_urow_ready),
    .sys_locked(sys_locked), .sys_crc_status(sys_crc_status), .sys_reset_request(sys_reset_request),
    .system_clock_request(system_clock_request), .user_row_program(user_row_program),
    .access_layer_enable(access_layer_enable), .debug_clock_tick(debug_clock_tick)
  );

  dpsc_sys_model dpsc_sys_model_i
  (
    .clk(clk), .reset_req(sys_reset_request), .erase_bad(erase_bad),
    .in_reset(sys_in_reset), .boot_done(sys_boot_done), .erase_fail(sys_erase_fail)
  );

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // strobes rise one edge after entry, so back-to-back calls never reassign
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    idle(1);
    reg_addr = a;
    reg_wdata = d;
    reg_we = 1'b1;
    idle(1);
    reg_we = 1'b0;
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] exp);
    idle(1);
    reg_addr = a;
    reg_re = 1'b1;
    idle(1);
    reg_re = 1'b0;
    chk("rvalid", 8'h01, 8'(reg_rvalid));
    chk(nm, exp, reg_rdata);
  endtask

  task automatic tgap;
    gap = 0;
    do
    begin
      idle(1);
      gap++;
    end
    while (debug_clock_tick !== 1'b1 && gap < 99);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #100000;
    err_total++;
    $display("Error watchdog expected done seen timeout");
    close_out();
  end

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial
  begin
    idle(5);
    srst = 1'b0;
    chk("access", 8'h00, 8'(access_layer_enable));
    rd("status", 8'h0b, dpsc_pkg::STATUS_RESET);
    // boot still running, no system reset: only the boot gate holds access shut
    chk("access", 8'h00, 8'(access_layer_enable));
    rd("divider", 8'h09, 8'h03);
    rd("crc", 8'h0c, 8'h00);
    rd("request", 8'h08, 8'h00);
    rd("unmapped", 8'h0d, 8'h00);
    $display("test reset values done");
    debug_enable = 1'b1;
    idle(3);
    rd("control", 8'h0a, 8'h01);
    wr(8'h0a, 8'h00);
    chk("system_clock_request", 8'h00, 8'(system_clock_request));
    sys_asleep = 1'b1;
    wr(8'h0a, 8'h01);
    idle(8);
    rd("status", 8'h0b, 8'h93);
    chk("system_clock_request", 8'h01, 8'(system_clock_request));
    sys_asleep = 1'b0;
    $display("test clock request done");
    for (int i = 1; i < 4; i++)
    begin
      wr(8'h09, 8'(i));
      rd("divider", 8'h09, 8'(i));
      tgap();
      tgap();
      n_checks++;
      // whole-cycle periods cannot hit the rates exactly; allow one cycle
      if (gap != div_v[i] + 1 && gap != div_v[i] + 2)
      begin
        err_total++;
        $display("Error tick gap expected %0d seen %0d", div_v[i] + 1, gap);
      end
    end
    wr(8'h09, 8'h00);
    gap = 0;
    repeat (80)
    begin
      idle(1);
      gap += 32'(debug_clock_tick !== 1'b0);
    end
    chk("ticks", 8'h00, 8'(gap));
    debug_enable = 1'b0;
    idle(3);
    debug_enable = 1'b1;
    idle(3);
    rd("divider", 8'h09, 8'h03);
    $display("test clock select done");
    sys_urow_ready = 1'b1;
    idle(8);
    rd("status", 8'h0b, 8'h87);
    wr(8'h0a, 8'h03);
    chk("urow", 8'h00, 8'(user_row_program));
    user_row_key_ok = 1'b1;
    wr(8'h0a, 8'h03);
    chk("urow", 8'h01, 8'(user_row_program));
    idle(1);
    chk("urow", 8'h00, 8'(user_row_program));
    rd("control", 8'h0a, 8'h01);
    user_row_key_ok = 1'b0;
    sys_urow_ready = 1'b0;
    $display("test user row done");
    sys_nvm_ready = 1'b1;
    erase_bad = 1'b1;
    idle(8);
    erase_bad = 1'b0;
    rd("status", 8'h0b, 8'hcb);
    wr(8'h08, 8'h33);
    rd("request", 8'h08, 8'h00);
    wr(8'h08, dpsc_pkg::RESET_CODE_NORMAL);
    sys_nvm_ready = 1'b0;
    idle(20);
    chk("reset", 8'h01, 8'(sys_reset_request));
    chk("access", 8'h00, 8'(access_layer_enable));
    rd("request", 8'h08, 8'h59);
    rd("status", 8'h0b, 8'h21);
    rd("status", 8'h0b, 8'h21);
    wr(8'h08, dpsc_pkg::RESET_CODE_RUN);
    chk("reset", 8'h00, 8'(sys_reset_request));
    idle(30);
    rd("status", 8'h0b, 8'ha3);
    rd("status", 8'h0b, 8'h83);
    chk("access", 8'h01, 8'(access_layer_enable));
    $display("test reset request done");
    sys_locked = 1'b0;
    idle(8);
    rd("status", 8'h0b, 8'h82);
    for (int i = 0; i < 4; i++)
    begin
      sys_crc_status = (i == 0) ? 3'h0 : 3'(1 << (i - 1));
      idle(8);
      rd("crc", 8'h0c, {5'h00, sys_crc_status});
    end
    $display("test lock and crc done");
    close_out();
  end
endmodule
